// File: rtl/usbds_source.v
// Descriptor byte source for the interrupt endpoint, other-speed, qualifier and strings.
//
// How it works
// - Interrupt endpoint bytes are fixed constants except the interval.
// - Polling interval from EEPROM, else 04h.
// - Other-speed header bytes fixed: 09,07,0027,01,01.
// - Other-speed uses configuration of unused speed.
// - Power default 01h self, FAh bus.
// - Attributes default A0h, strap may alter.
// - Qualifier fixed bytes: 0A,06,0200,40,01,00.
// - Qualifier class fields from opposite speed.
// - Index 0 returns 04,03,EEPROM 0Ah-0Bh.
// - Index 0 stalls without EEPROM or strings.
// - Language identifier is never checked.
// - Index 1-5 stalls if absent.
// - String bytes pass from EEPROM unchanged.
`timescale 1ns/1ps
`include "usbds_defs.vh"
module usbds_source #(
   parameter EE_AW = 9
) (
   // Clock and reset
   input wire ref_clk_i,
   input wire arst_n_i,
   // Strap pin
   input wire remote_wakeup_strap_i,
   // Operating state
   input wire high_speed_i,
   input wire self_powered_i,
   input wire eeprom_valid_i,
   // EEPROM-derived fields
   input wire [7:0] ee_interval_i,
   input wire [7:0] ee_hs_iconfig_i,
   input wire [7:0] ee_hs_attr_i,
   input wire [7:0] ee_hs_power_i,
   input wire [7:0] ee_fs_iconfig_i,
   input wire [7:0] ee_fs_attr_i,
   input wire [7:0] ee_fs_power_i,
   input wire [7:0] dev_hs_class_i,
   input wire [7:0] dev_hs_subclass_i,
   input wire [7:0] dev_hs_protocol_i,
   input wire [7:0] dev_fs_class_i,
   input wire [7:0] dev_fs_subclass_i,
   input wire [7:0] dev_fs_protocol_i,
   input wire [39:0] ee_str_len_i,
   input wire [39:0] ee_str_off_i,
   // EEPROM byte read port, data taken in the same cycle as the strobe
   output reg ee_rd_o,
   output reg [EE_AW-1:0] ee_addr_o,
   input wire [7:0] ee_data_i,
   // Request
   input wire req_valid_i,
   output wire req_ready_o,
   input wire [7:0] req_type_i,
   input wire [7:0] req_index_i,
   input wire [15:0] req_langid_i,
   input wire [15:0] req_length_i,
   // Answer
   output reg stall_o,
   output reg done_o,
   output reg byte_valid_o,
   output reg [7:0] byte_data_o,
   output reg byte_last_o,
   input wire byte_ready_i
);

   // ----------------------------------------------------------------------
   // Kinds and states
   // ----------------------------------------------------------------------
   localparam [2:0] K_EP = 3'h0;
   localparam [2:0] K_OSC = 3'h1;
   localparam [2:0] K_DQ = 3'h2;
   localparam [2:0] K_LANG = 3'h3;
   localparam [2:0] K_STR = 3'h4;
   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_FETCH = 2'h1;
   localparam [1:0] S_SEND = 2'h2;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function [7:0] str_field;
      input [39:0] vec;
      input [2:0] idx;
      begin
         case (idx)
            3'h1: str_field = vec[7:0];
            3'h2: str_field = vec[15:8];
            3'h3: str_field = vec[23:16];
            3'h4: str_field = vec[31:24];
            3'h5: str_field = vec[39:32];
            default: str_field = 8'h00;
         endcase
      end
   endfunction
   function [15:0] min16;
      input [15:0] a;
      input [15:0] b;
      begin
         min16 = (a < b) ? a : b;
      end
   endfunction

   // ----------------------------------------------------------------------
   // Strap
   // ----------------------------------------------------------------------
   wire strap;
   wire strap_valid;
   usbds_strap_sync u_strap (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .remote_wakeup_strap_i(remote_wakeup_strap_i),
      .strap_o(strap),
      .strap_valid_o(strap_valid)
   );

   // ----------------------------------------------------------------------
   // Derived field values
   // ----------------------------------------------------------------------
   wire [7:0] interval = eeprom_valid_i ? ee_interval_i : `USBDS_EP_INTERVAL_DEF;
   wire [7:0] osc_iconfig = high_speed_i ? ee_fs_iconfig_i : ee_hs_iconfig_i;
   wire [7:0] osc_ee_attr = high_speed_i ? ee_fs_attr_i : ee_hs_attr_i;
   wire [7:0] osc_ee_power = high_speed_i ? ee_fs_power_i : ee_hs_power_i;
   reg [7:0] attr_def;
   always @* begin
      attr_def = `USBDS_OSC_ATTR_DEF;
      attr_def[`USBDS_ATTR_WAKE_BIT] = strap_valid ? strap : 1'b1;
   end
   wire [7:0] osc_attr = eeprom_valid_i ? osc_ee_attr : attr_def;
   wire [7:0] pwr_def = self_powered_i ? `USBDS_PWR_SELF_DEF : `USBDS_PWR_BUS_DEF;
   wire [7:0] osc_power = eeprom_valid_i ? osc_ee_power : pwr_def;
   wire [7:0] dq_class = high_speed_i ? dev_fs_class_i : dev_hs_class_i;
   wire [7:0] dq_subclass = high_speed_i ? dev_fs_subclass_i : dev_hs_subclass_i;
   wire [7:0] dq_protocol = high_speed_i ? dev_fs_protocol_i : dev_hs_protocol_i;
   wire [15:0] ep_maxpkt = `USBDS_EP_MAXPKT;
   wire [15:0] osc_total = `USBDS_OSC_TOTAL;
   wire [15:0] dq_bcd = `USBDS_DQ_BCD;
   // ----------------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------------
   wire any_string = |ee_str_len_i;
   wire [2:0] sidx = req_index_i[2:0];
   wire sidx_ok = (req_index_i >= 8'h01) && (req_index_i <= 8'h05);
   wire [7:0] sel_len = str_field(ee_str_len_i, sidx);
   wire [7:0] sel_off = str_field(ee_str_off_i, sidx);
   // The language identifier port is deliberately not decoded.
   reg [2:0] dec_kind;
   reg dec_stall;
   reg [15:0] dec_len;
   always @* begin
      dec_kind = K_EP;
      dec_stall = 1'b0;
      dec_len = 16'h0000;
      case (req_type_i)
         `USBDS_TYPE_ENDPOINT: begin
            dec_kind = K_EP;
            dec_len = {8'h00, `USBDS_EP_LEN};
         end
         `USBDS_TYPE_OTHER_SPEED: begin
            dec_kind = K_OSC;
            dec_len = {8'h00, `USBDS_OSC_LEN};
         end
         `USBDS_TYPE_QUALIFIER: begin
            dec_kind = K_DQ;
            dec_len = {8'h00, `USBDS_DQ_LEN};
         end
         `USBDS_TYPE_STRING: begin
            if (req_index_i == 8'h00) begin
               dec_kind = K_LANG;
               dec_len = {8'h00, `USBDS_LANG_LEN};
               dec_stall = !eeprom_valid_i || !any_string;
            end else begin
               dec_kind = K_STR;
               dec_len = {8'h00, sel_len};
               dec_stall = !sidx_ok || !eeprom_valid_i ||
                  ((sel_len == 8'h00) && (sel_off == 8'h00));
            end
         end
         default: begin
            dec_stall = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Transfer state
   // ----------------------------------------------------------------------
   reg [1:0] state;
   reg [2:0] kind;
   reg [15:0] limit;
   reg [15:0] count;
   reg [7:0] str_base;
   assign req_ready_o = (state == S_IDLE);
   // Fixed bytes, multi-byte fields low byte first.
   reg [7:0] table_byte;
   reg table_from_ee;
   always @* begin
      table_byte = 8'h00;
      table_from_ee = 1'b0;
      case (kind)
         K_EP: begin
            case (count[3:0])
               4'h0: table_byte = `USBDS_EP_LEN;
               4'h1: table_byte = `USBDS_TYPE_ENDPOINT;
               4'h2: table_byte = `USBDS_EP_ADDR;
               4'h3: table_byte = `USBDS_EP_ATTR;
               4'h4: table_byte = ep_maxpkt[7:0];
               4'h5: table_byte = ep_maxpkt[15:8];
               default: table_byte = interval;
            endcase
         end
         K_OSC: begin
            case (count[3:0])
               4'h0: table_byte = `USBDS_OSC_LEN;
               4'h1: table_byte = `USBDS_TYPE_OTHER_SPEED;
               4'h2: table_byte = osc_total[7:0];
               4'h3: table_byte = osc_total[15:8];
               4'h4: table_byte = `USBDS_OSC_NUM_IF;
               4'h5: table_byte = `USBDS_OSC_CFG_VAL;
               4'h6: table_byte = osc_iconfig;
               4'h7: table_byte = osc_attr;
               default: table_byte = osc_power;
            endcase
         end
         K_DQ: begin
            case (count[3:0])
               4'h0: table_byte = `USBDS_DQ_LEN;
               4'h1: table_byte = `USBDS_TYPE_QUALIFIER;
               4'h2: table_byte = dq_bcd[7:0];
               4'h3: table_byte = dq_bcd[15:8];
               4'h4: table_byte = dq_class;
               4'h5: table_byte = dq_subclass;
               4'h6: table_byte = dq_protocol;
               4'h7: table_byte = `USBDS_DQ_MAXPKT0;
               4'h8: table_byte = `USBDS_DQ_NUM_CFG;
               default: table_byte = `USBDS_DQ_RSVD;
            endcase
         end
         K_LANG: begin
            case (count[3:0])
               4'h0: table_byte = `USBDS_LANG_LEN;
               4'h1: table_byte = `USBDS_TYPE_STRING;
               default: table_from_ee = 1'b1;
            endcase
         end
         default: begin
            table_from_ee = 1'b1;
         end
      endcase
   end

   // EEPROM address of the current byte.
   wire [EE_AW-1:0] lang_addr = (count[0] == 1'b0) ? `USBDS_LANG_EE_LO : `USBDS_LANG_EE_HI;
   wire [EE_AW-1:0] str_addr = str_base + count[EE_AW-1:0];
   wire [EE_AW-1:0] cur_addr = (kind == K_LANG) ? lang_addr : str_addr;

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   // Each byte takes a fetch cycle so that EEPROM and fixed bytes share one
   // timing; the cost is two idle cycles per byte, far below any USB rate.
   reg fetch_ee;
   wire [15:0] next_count = count + 16'h0001;
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= S_IDLE;
         kind <= K_EP;
         limit <= 16'h0000;
         count <= 16'h0000;
         str_base <= 8'h00;
         fetch_ee <= 1'b0;
         ee_rd_o <= 1'b0;
         ee_addr_o <= {EE_AW{1'b0}};
         stall_o <= 1'b0;
         done_o <= 1'b0;
         byte_valid_o <= 1'b0;
         byte_data_o <= 8'h00;
         byte_last_o <= 1'b0;
      end else begin
         stall_o <= 1'b0;
         done_o <= 1'b0;
         ee_rd_o <= 1'b0;
         case (state)
            S_IDLE: begin
               if (req_valid_i) begin
                  kind <= dec_kind;
                  str_base <= sel_off;
                  count <= 16'h0000;
                  limit <= min16(req_length_i, dec_len);
                  if (dec_stall) begin
                     stall_o <= 1'b1;
                  end else if (min16(req_length_i, dec_len) == 16'h0000) begin
                     done_o <= 1'b1;
                  end else begin
                     state <= S_FETCH;
                  end
               end
            end
            S_FETCH: begin
               fetch_ee <= table_from_ee;
               if (table_from_ee) begin
                  ee_rd_o <= 1'b1;
                  ee_addr_o <= cur_addr;
               end else begin
                  byte_data_o <= table_byte;
               end
               byte_last_o <= (next_count == limit);
               state <= S_SEND;
            end
            S_SEND: begin
               if (!byte_valid_o) begin
                  if (fetch_ee) begin
                     byte_data_o <= ee_data_i;
                  end
                  byte_valid_o <= 1'b1;
               end else if (byte_ready_i) begin
                  byte_valid_o <= 1'b0;
                  count <= next_count;
                  if (byte_last_o) begin
                     byte_last_o <= 1'b0;
                     done_o <= 1'b1;
                     state <= S_IDLE;
                  end else begin
                     state <= S_FETCH;
                  end
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

endmodule

// File: rtl/usbds_defs.vh
// Constants of the USB descriptor source: descriptor codes, fixed fields and EEPROM defaults.
`ifndef USBDS_DEFS_VH
`define USBDS_DEFS_VH

// ----------------------------------------------------------------------
// Descriptor type codes
// ----------------------------------------------------------------------
`define USBDS_TYPE_STRING 8'h03
`define USBDS_TYPE_ENDPOINT 8'h05
`define USBDS_TYPE_QUALIFIER 8'h06
`define USBDS_TYPE_OTHER_SPEED 8'h07

// ----------------------------------------------------------------------
// Interrupt endpoint descriptor
// ----------------------------------------------------------------------
`define USBDS_EP_LEN 8'h07
`define USBDS_EP_ADDR 8'h83
`define USBDS_EP_ATTR 8'h03
`define USBDS_EP_MAXPKT 16'h0010
`define USBDS_EP_INTERVAL_DEF 8'h04

// ----------------------------------------------------------------------
// Other-speed configuration descriptor
// ----------------------------------------------------------------------
`define USBDS_OSC_LEN 8'h09
`define USBDS_OSC_TOTAL 16'h0027
`define USBDS_OSC_NUM_IF 8'h01
`define USBDS_OSC_CFG_VAL 8'h01
`define USBDS_OSC_ATTR_DEF 8'hA0
`define USBDS_ATTR_SELF_BIT 6
`define USBDS_ATTR_WAKE_BIT 5
`define USBDS_PWR_SELF_DEF 8'h01
`define USBDS_PWR_BUS_DEF 8'hFA

// ----------------------------------------------------------------------
// Device qualifier descriptor
// ----------------------------------------------------------------------
`define USBDS_DQ_LEN 8'h0A
`define USBDS_DQ_BCD 16'h0200
`define USBDS_DQ_MAXPKT0 8'h40
`define USBDS_DQ_NUM_CFG 8'h01
`define USBDS_DQ_RSVD 8'h00

// ----------------------------------------------------------------------
// String descriptors
// ----------------------------------------------------------------------
`define USBDS_LANG_LEN 8'h04
`define USBDS_LANG_EE_LO 9'h00A
`define USBDS_LANG_EE_HI 9'h00B
`define USBDS_NUM_STR 5

`endif

// File: rtl/usbds_strap_sync.v
// Synchroniser and reset-release capture of the remote wakeup strap pin.
`timescale 1ns/1ps
module usbds_strap_sync (
   // Clock and reset
   input wire ref_clk_i,
   input wire arst_n_i,
   // Strap pin
   input wire remote_wakeup_strap_i,
   // Captured level
   output reg strap_o,
   output reg strap_valid_o
);

   reg meta;
   reg sync;
   reg [1:0] wait_cnt;

   // The strap is only meaningful at power-up, so it is frozen once the
   // synchroniser has settled after reset release.
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta <= 1'b0;
         sync <= 1'b0;
         wait_cnt <= 2'h0;
         strap_o <= 1'b0;
         strap_valid_o <= 1'b0;
      end else begin
         meta <= remote_wakeup_strap_i;
         sync <= meta;
         if (wait_cnt != 2'h2) begin
            wait_cnt <= wait_cnt + 2'h1;
         end else if (!strap_valid_o) begin
            strap_o <= sync;
            strap_valid_o <= 1'b1;
         end
      end
   end

endmodule

// File: test/usbds_eeprom_model.sv
// Behavioural EEPROM byte store that answers the descriptor source's read port.
`timescale 1ns/1ps
module usbds_eeprom_model (
   // Clock and reset
   input wire ref_clk_i,
   input wire arst_n_i,
   // Read port
   input wire ee_rd_i,
   input wire [8:0] ee_addr_i,
   output wire [7:0] ee_data_o
);
   // The source takes the byte at the edge that ends its strobe cycle, so data
   // stands only while the strobe does; otherwise the bus shows a byte that is
   // never the right one, so a sample taken early or late cannot be lucky.
   reg noise;
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         noise <= 1'b0;
      end else begin
         noise <= ~noise;
      end
   end
   assign ee_data_o = ee_rd_i ? (ee_addr_i[7:0] ^ 8'h5a) :
      (~(ee_addr_i[7:0] ^ 8'h5a) ^ {7'h00, noise});
endmodule

// File: test/usbds_source_checker.sv
// Concurrent checks on the answer timing of the descriptor source.
`timescale 1ns/1ps
module usbds_source_checker (
   // Clock, reset and inputs
   input wire ref_clk_i,
   input wire arst_n_i,
   input wire eeprom_valid_i,
   input wire req_valid_i,
   input wire [7:0] req_type_i,
   input wire [15:0] req_length_i,
   input wire byte_ready_i,
   // Outputs
   input wire req_ready_o,
   input wire stall_o,
   input wire done_o,
   input wire ee_rd_o,
   input wire byte_valid_o,
   input wire [7:0] byte_data_o,
   input wire byte_last_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   wire taken = req_valid_i && req_ready_o;
   wire moved = byte_valid_o && byte_ready_i;

   property p_stall_pulse; stall_o |-> !byte_valid_o && !done_o ##1 !stall_o; endproperty
   a_stall_pulse: assert property (p_stall_pulse) else $error("stall not a lone pulse");
   property p_done_pulse; done_o |=> !done_o; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done held");
   property p_busy; taken |=> req_ready_o == (stall_o || done_o); endproperty
   a_busy: assert property (p_busy) else $error("ready wrong after request");
   property p_hold; byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_data_o)
      && $stable(byte_last_o); endproperty
   a_hold: assert property (p_hold) else $error("byte changed while waiting");
   property p_gap; moved && !byte_last_o |=> !byte_valid_o ##[1:2] byte_valid_o; endproperty
   a_gap: assert property (p_gap) else $error("next byte not offered");
   property p_last; moved && byte_last_o |=> done_o && !byte_valid_o; endproperty
   a_last: assert property (p_last) else $error("no done after last byte");
   property p_no_ee; taken && !eeprom_valid_i && req_type_i == 8'h03 |=> stall_o; endproperty
   a_no_ee: assert property (p_no_ee) else $error("string without eeprom not stalled");
   property p_ep_first; taken && req_type_i == 8'h05 && req_length_i != 16'h0000
      |-> ##3 byte_valid_o && byte_data_o == 8'h07; endproperty
   a_ep_first: assert property (p_ep_first) else $error("endpoint first byte wrong");
   property p_rd_pulse; ee_rd_o |=> !ee_rd_o; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("eeprom strobe held");

   c_stall: cover property (stall_o);
   c_last: cover property (moved && byte_last_o);
   c_read: cover property (ee_rd_o);
   c_wait: cover property (byte_valid_o && !byte_ready_i);
endmodule

bind usbds_source usbds_source_checker chk_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
   .eeprom_valid_i(eeprom_valid_i), .req_valid_i(req_valid_i), .req_type_i(req_type_i),
   .req_length_i(req_length_i), .byte_ready_i(byte_ready_i), .req_ready_o(req_ready_o),
   .stall_o(stall_o), .done_o(done_o), .ee_rd_o(ee_rd_o), .byte_valid_o(byte_valid_o),
   .byte_data_o(byte_data_o), .byte_last_o(byte_last_o));

// File: test/usb_descriptor_source_tb_top.sv
// Self-checking bench of the descriptor source.
`timescale 1ns/1ps
module usb_descriptor_source_tb_top;
   reg ref_clk_i = 1'b0, arst_n_i = 1'b0, strap = 1'b1;
   reg high_speed_i = 1'b0, self_powered_i = 1'b0, eeprom_valid_i = 1'b0;
   reg [7:0] f [0:12];
   reg [39:0] str_len = 40'h00_0000_0000, str_off = 40'h00_0000_0000;
   wire ee_rd, req_ready_o, stall_o, done_o, byte_valid_o, byte_last_o;
   wire [8:0] ee_addr;
   wire [7:0] ee_data, byte_data_o;
   reg req_valid_i = 1'b0, byte_ready_i = 1'b0, st;
   reg [7:0] req_type_i = 8'h00, req_index_i = 8'h00;
   reg [15:0] req_langid_i = 16'h0000, req_length_i = 16'h0000;
   reg [15:0] rs = 16'hce20, bs = 16'hce20;
   reg [7:0] d [0:255];
   reg [9:0] q [$];
   integer errors = 0, comparisons = 0, cycles = 0, n, i, t, h;

   always #2.5 ref_clk_i = ~ref_clk_i;

   usbds_source dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
      .remote_wakeup_strap_i(strap), .high_speed_i(high_speed_i),
      .self_powered_i(self_powered_i), .eeprom_valid_i(eeprom_valid_i),
      .ee_interval_i(f[0]), .ee_hs_iconfig_i(f[1]), .ee_hs_attr_i(f[2]), .ee_hs_power_i(f[3]),
      .ee_fs_iconfig_i(f[4]), .ee_fs_attr_i(f[5]), .ee_fs_power_i(f[6]),
      .dev_hs_class_i(f[7]), .dev_hs_subclass_i(f[8]), .dev_hs_protocol_i(f[9]),
      .dev_fs_class_i(f[10]), .dev_fs_subclass_i(f[11]), .dev_fs_protocol_i(f[12]),
      .ee_str_len_i(str_len), .ee_str_off_i(str_off), .ee_rd_o(ee_rd), .ee_addr_o(ee_addr),
      .ee_data_i(ee_data), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
      .req_type_i(req_type_i), .req_index_i(req_index_i), .req_langid_i(req_langid_i),
      .req_length_i(req_length_i), .stall_o(stall_o), .done_o(done_o),
      .byte_valid_o(byte_valid_o), .byte_data_o(byte_data_o), .byte_last_o(byte_last_o),
      .byte_ready_i(byte_ready_i));

   usbds_eeprom_model ee_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ee_rd_i(ee_rd),
      .ee_addr_i(ee_addr), .ee_data_o(ee_data));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function [15:0] nxt(input [15:0] s);
      nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function [7:0] mem(input [8:0] a);
      mem = a[7:0] ^ 8'h5a;
   endfunction

   task conclude;
      begin
         if (errors == 0 && comparisons > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask

   task check(input [8*8-1:0] name, input [9:0] seen, input [9:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask

   // Works out the answer from the inputs as they stand when the request is made.
   task automatic build(input [7:0] ty, input [7:0] ix);
      reg [79:0] v;
      reg [7:0] a, p, l, o;
      integer g;
      begin
         st = 1'b0;
         n = 0;
         l = 8'h00;
         o = 8'h00;
         a = eeprom_valid_i ? (high_speed_i ? f[5] : f[2]) : {2'b10, strap, 5'h00};
         p = eeprom_valid_i ? (high_speed_i ? f[6] : f[3]) : (self_powered_i ? 8'h01 : 8'hfa);
         case (ty)
            8'h05: begin
               v = {24'h00_0000, eeprom_valid_i ? f[0] : 8'h04, 48'h0010_0383_0507};
               n = 7;
            end
            8'h07: begin
               v = {8'h00, p, a, high_speed_i ? f[4] : f[1], 48'h0101_0027_0709};
               n = 9;
            end
            8'h06: begin
               g = high_speed_i ? 10 : 7;
               v = {24'h00_0140, f[g + 2], f[g + 1], f[g], 32'h0200_060a};
               n = 10;
            end
            8'h03: begin
               if (ix == 8'h00) begin
                  v = {48'h0000_0000_0000, mem(9'h00b), mem(9'h00a), 16'h0304};
                  st = !eeprom_valid_i || str_len == 40'h00_0000_0000;
                  n = 4;
               end else if (ix <= 8'h05) begin
                  l = str_len[8 * (ix - 1) +: 8];
                  o = str_off[8 * (ix - 1) +: 8];
                  st = !eeprom_valid_i || (l == 8'h00 && o == 8'h00);
                  n = l;
               end else begin
                  st = 1'b1;
               end
            end
            default: begin
               st = 1'b1;
            end
         endcase
         for (i = 0; i < n; i = i + 1) begin
            d[i] = (ty == 8'h03 && ix != 8'h00) ? mem({1'b0, o} + i) : v[8 * i +: 8];
         end
      end
   endtask

   // Called at a falling edge; returns at a falling edge after the answer ends.
   task automatic req(input [7:0] ty, input [7:0] ix, input [15:0] len);
      integer k;
      begin
         build(ty, ix);
         if (st) q.push_back(10'h200);
         else begin
            k = (len < n) ? len : n;
            for (i = 0; i < k; i = i + 1) q.push_back({1'b0, i == k - 1, d[i]});
            q.push_back(10'h300);
         end
         rs = nxt(rs);
         req_langid_i = rs;
         req_type_i = ty;
         req_index_i = ix;
         req_length_i = len;
         req_valid_i = 1'b1;
         @(posedge ref_clk_i);
         while (!req_ready_o) @(posedge ref_clk_i);
         @(negedge ref_clk_i);
         req_valid_i = 1'b0;
         do @(posedge ref_clk_i); while (!(done_o || stall_o));
         @(negedge ref_clk_i);
      end
   endtask

   task rst(input s);
      begin
         arst_n_i = 1'b0;
         strap = s;
         repeat (8) @(negedge ref_clk_i);
         arst_n_i = 1'b1;
         repeat (4) @(negedge ref_clk_i);
      end
   endtask

   // ---------------------------------------------------------------
   // Far-side stalls, answer monitor and hang guard
   // ---------------------------------------------------------------
   always @(negedge ref_clk_i) begin
      bs = nxt(bs);
      byte_ready_i <= bs[0] | bs[3];
   end

   task obs(input [9:0] v);
      begin
         if (q.size() == 0) check("answer", v, 10'h3ff);
         else check("answer", v, q.pop_front());
      end
   endtask

   always @(posedge ref_clk_i) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         conclude;
      end
      if (byte_valid_o && byte_ready_i) obs({1'b0, byte_last_o, byte_data_o});
      if (stall_o) obs(10'h200);
      if (done_o) obs(10'h300);
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      for (i = 0; i < 13; i = i + 1) f[i] = 8'h00;
      rst(1'b1);
      req(8'h05, 8'h00, 16'h0040);
      req(8'h07, 8'h00, 16'h00ff);
      self_powered_i = 1'b1;
      req(8'h07, 8'h00, 16'h0009);
      req(8'h06, 8'h00, 16'h000a);
      high_speed_i = 1'b1;
      req(8'h06, 8'h00, 16'h00ff);
      req(8'h03, 8'h00, 16'h00ff);
      req(8'h03, 8'h03, 16'h00ff);
      req(8'h09, 8'h00, 16'h0008);
      eeprom_valid_i = 1'b1;
      for (i = 0; i < 13; i = i + 1) begin
         rs = nxt(rs);
         f[i] = rs[7:0];
      end
      str_len = 40'h04_0900_0006;
      str_off = 40'h50_4030_0020;
      for (t = 0; t < 7; t = t + 1) req(8'h03, t[7:0], 16'h00ff);
      req(8'h03, 8'h00, 16'h00ff);
      req(8'h03, 8'h04, 16'h0005);
      for (h = 0; h < 2; h = h + 1) begin
         high_speed_i = h[0];
         for (t = 5; t < 8; t = t + 1) req(t[7:0], 8'h00, 16'h00ff);
      end
      for (t = 0; t < 4; t = t + 1) begin
         rs = nxt(rs);
         req(8'h07, 8'h00, {12'h000, rs[3:0]});
      end
      req(8'h06, 8'h00, 16'h0000);
      str_len = 40'h00_0000_0000;
      req(8'h03, 8'h00, 16'h00ff);
      eeprom_valid_i = 1'b0;
      self_powered_i = 1'b0;
      high_speed_i = 1'b0;
      rst(1'b0);
      req(8'h07, 8'h00, 16'h00ff);
      check("pending", q.size(), 10'h000);
      conclude;
   end
endmodule
